// ==== design/dlpi_pkg.sv ====
package dlpi_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_TAPS = 256;
  // pin timing in ns, clock period 5 ns
  localparam int CLK_NS = 5;
  localparam int CLK_HALF_NS = 15;        // serial clock phase, >= 10 ns
  localparam int ENABLE_SETUP_NS = 20;    // enable setup / out valid
  localparam int PARALLEL_SETTLE_NS = 40;
  localparam int ENABLE_SETTLE_NS = 45;
  localparam int ENABLE_WIDTH_NS = 10;
  localparam int HALF_CYC = (CLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (ENABLE_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PSETTLE_CYC = (PARALLEL_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ESETTLE_CYC = (ENABLE_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int EWIDTH_CYC = (ENABLE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  // input idle time before an update: set for the longest delay, cycles
  localparam int IDLE_CYC = 800;
  localparam int CNT_W = 10;
  localparam logic [1:0] OP_TRANSPARENT = 2'h0;
  localparam logic [1:0] OP_LATCHED = 2'h1;
  localparam logic [1:0] OP_SERIAL = 2'h2;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  typedef enum logic [2:0] {
    DLPI_IDLE, DLPI_QUIET, DLPI_SETUP, DLPI_SHIFT_LO, DLPI_SHIFT_HI,
    DLPI_HOLD, DLPI_SETTLE
  } dlpi_state_t;
endpackage : dlpi_pkg

// ==== design/dlpi_host.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - hold delayed input idle before address change
// - wait settling time before input toggles again
// - host registers the value driven on pins
// - cascade sends eight bits per device
// - readback must be shifted back before enable falls; the host does so only when req_restore is set
module dlpi_host (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // user request
  input  wire logic                        req_valid,
  input  wire logic [1:0]                  req_op,
  input  wire logic [dlpi_pkg::ADDR_W-1:0] req_addr,
  input  wire logic                        req_restore,
  output logic                             req_ready,
  output logic                             done,
  output logic [dlpi_pkg::ADDR_W-1:0]      read_addr,
  // delayed signal gating
  output logic                             signal_hold,
  // device pins
  output logic                             delay_mode_select,
  output logic                             address_enable,
  output logic [dlpi_pkg::ADDR_W-1:0]      parallel_program_pins,
  output logic                             serial_shift_clock,
  output logic                             serial_data_in,
  input  wire logic                        serial_data_out
);
  import dlpi_pkg::*;

  dlpi_state_t          state;
  logic [CNT_W-1:0]     cnt;
  logic [2:0]           bit_idx;
  logic [1:0]           op;
  logic                 restore;
  logic [ADDR_W-1:0]    tx;
  logic [ADDR_W-1:0]    rx;
  logic                 so_meta;
  logic                 so_sync;
  logic                 pass2;
  logic                 sclk_prev;
  logic [4:0]           rise_cnt;
  logic [CNT_W-1:0]     hold_age;

  // the device's output is a pin, so it is synchronised
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      so_meta <= 1'b0;
      so_sync <= 1'b0;
    end else begin
      so_meta <= serial_data_out;
      so_sync <= so_meta;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= DLPI_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        DLPI_IDLE: if (req_valid) begin
          state <= DLPI_QUIET;
          cnt <= CNT_W'(IDLE_CYC - 1);
        end
        DLPI_QUIET: if (cnt == '0) begin
          state <= DLPI_SETUP;
          cnt <= (op == OP_SERIAL) ? CNT_W'(SETUP_CYC - 1)
                 : CNT_W'(EWIDTH_CYC - 1);
        end else cnt <= cnt - 1'b1;
        DLPI_SETUP: if (cnt == '0) begin
          if (op == OP_SERIAL) begin
            state <= DLPI_SHIFT_LO;
            cnt <= CNT_W'(HALF_CYC - 1);
          end else begin
            state <= DLPI_SETTLE;
            // enable falls one cycle after entry, so latched counts one more
            cnt <= (op == OP_TRANSPARENT) ? CNT_W'(PSETTLE_CYC - 1)
                   : CNT_W'(ESETTLE_CYC);
          end
        end else cnt <= cnt - 1'b1;
        DLPI_SHIFT_LO: if (cnt == '0) begin
          state <= DLPI_SHIFT_HI;
          cnt <= CNT_W'(HALF_CYC - 1);
        end else cnt <= cnt - 1'b1;
        DLPI_SHIFT_HI: if (cnt == '0) begin
          // a restore reads eight, then writes them back before enable falls
          state <= (bit_idx == 3'h0 && !(restore && !pass2)) ? DLPI_HOLD
                   : DLPI_SHIFT_LO;
          cnt <= CNT_W'(HALF_CYC - 1);
        end else cnt <= cnt - 1'b1;
        DLPI_HOLD: if (cnt == '0) begin
          state <= DLPI_SETTLE;
          cnt <= CNT_W'(ESETTLE_CYC);
        end else cnt <= cnt - 1'b1;
        DLPI_SETTLE: if (cnt == '0) state <= DLPI_IDLE;
        else cnt <= cnt - 1'b1;
      endcase
    end
  end

  // request capture
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      op <= OP_TRANSPARENT;
      restore <= 1'b0;
    end else if (state == DLPI_IDLE && req_valid) begin
      op <= req_op;
      restore <= req_restore;
    end
  end

  // pins move only after the quiet time, else the line could glitch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      parallel_program_pins <= ADDR_RESET;
    end else if (state == DLPI_QUIET && cnt == '0 && op != OP_SERIAL) begin
      parallel_program_pins <= tx;
    end
  end

  // serial shifter, msb first; rx samples just before each rising edge of the first pass
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx <= ADDR_RESET;
      rx <= ADDR_RESET;
      bit_idx <= 3'h7;
      pass2 <= 1'h0;
    end else if (state == DLPI_IDLE && req_valid) begin
      tx <= req_addr;
      bit_idx <= 3'h7;
      pass2 <= 1'h0;
    end else if (state == DLPI_SHIFT_LO && cnt == '0 && !pass2) begin
      rx <= {rx[ADDR_W-2:0], so_sync};
    end else if (state == DLPI_SHIFT_HI && cnt == '0) begin
      // the read is destructive, so the second pass sends it back
      if (bit_idx == 3'h0 && restore && !pass2) begin
        tx <= rx;
        pass2 <= 1'h1;
      end else begin
        tx <= {tx[ADDR_W-2:0], 1'b0};
      end
      bit_idx <= bit_idx - 1'b1;
    end
  end

  // pin drive: mode select is a level, enable shape picks the mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      delay_mode_select <= 1'b1;
      address_enable <= 1'b1;
      serial_shift_clock <= 1'b0;
      serial_data_in <= 1'b0;
    end else begin
      if (state == DLPI_QUIET && cnt == '0)
        delay_mode_select <= (op != OP_SERIAL);
      unique case (state)
        // enable keeps its level until the quiet time is over
        DLPI_IDLE, DLPI_QUIET: address_enable <= address_enable;
        DLPI_SETUP: address_enable <= 1'b1;
        DLPI_SHIFT_LO, DLPI_SHIFT_HI: address_enable <= 1'b1;
        DLPI_HOLD:  address_enable <= 1'b1;
        DLPI_SETTLE: address_enable <= (op == OP_TRANSPARENT);
      endcase
      serial_shift_clock <= (state == DLPI_SHIFT_HI);
      serial_data_in <= tx[ADDR_W-1];
    end
  end

  // hold the delayed signal through the update and settling
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      signal_hold <= 1'b0;
      req_ready <= 1'b0;
      done <= 1'b0;
      read_addr <= ADDR_RESET;
    end else begin
      signal_hold <= (state != DLPI_IDLE) && !(state == DLPI_SETTLE
                     && cnt == '0);
      req_ready <= (state == DLPI_IDLE) && !req_valid;
      done <= (state == DLPI_SETTLE) && (cnt == '0);
      if (state == DLPI_SETTLE && cnt == '0 && op == OP_SERIAL)
        read_addr <= rx;
    end
  end

  // cycles the delayed input has been held so far
  always_ff @(posedge clock) begin
    if (sys_rst || !signal_hold) begin
      hold_age <= '0;
    end else if (hold_age != '1) begin
      hold_age <= hold_age + 1'b1;
    end
  end

  // serial clock rises within one request
  always_ff @(posedge clock) begin
    if (sys_rst || state == DLPI_IDLE) begin
      sclk_prev <= 1'h0;
      rise_cnt <= 5'h00;
    end else begin
      sclk_prev <= serial_shift_clock;
      if (serial_shift_clock && !sclk_prev)
        rise_cnt <= rise_cnt + 5'h01;
    end
  end

  AST_SERIAL_ENABLE: assert property (
    @(posedge clock) disable iff (sys_rst)
    serial_shift_clock |-> address_enable)
    else $error("serial clock pulsed with enable low");
  AST_HOLD_QUIET: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(signal_hold) |-> signal_hold[*8])
    else $error("signal hold released early");
  AST_DONE_IDLE: assert property (
    @(posedge clock) disable iff (sys_rst)
    done |=> !signal_hold)
    else $error("hold still set after done");
  AST_MODE_LEVEL: assert property (
    @(posedge clock) disable iff (sys_rst)
    (state == DLPI_SHIFT_HI) |-> !delay_mode_select)
    else $error("mode select high during shift");
  AST_PINS_QUIET: assert property (
    @(posedge clock) disable iff (sys_rst)
    $changed(parallel_program_pins) |-> hold_age >= CNT_W'(IDLE_CYC - 1))
    else $error("program pins moved before the quiet time");
  AST_MODE_QUIET: assert property (
    @(posedge clock) disable iff (sys_rst)
    $changed(delay_mode_select) |-> hold_age >= CNT_W'(IDLE_CYC - 1))
    else $error("mode select moved before the quiet time");
  AST_SETTLE_HOLD: assert property (
    @(posedge clock) disable iff (sys_rst)
    $fell(address_enable) |=> signal_hold[*8])
    else $error("hold released before enable settling");
  AST_BIT_COUNT: assert property (
    @(posedge clock) disable iff (sys_rst)
    ($fell(address_enable) && !delay_mode_select) |->
      (rise_cnt[2:0] == 3'h0 && rise_cnt != 5'h00))
    else $error("serial frame not a multiple of eight bits");
endmodule : dlpi_host

// ==== verification/dlpi_dev_model.sv ====
`timescale 1ns/1ps
module dlpi_dev_model #(
  parameter logic [7:0] INIT = 8'h5a
) (
  // pins from the host
  input  wire logic       delay_mode_select,
  input  wire logic       address_enable,
  input  wire logic [7:0] parallel_program_pins,
  input  wire logic       serial_shift_clock,
  input  wire logic       serial_data_in,
  // readback and tap in use
  output logic            serial_data_out,
  output logic [7:0]      tap_addr
);
  logic [7:0] shift_reg = INIT;
  logic [7:0] held_addr = 8'h00;
  wire        ser_on = !delay_mode_select && address_enable;
  // msb first; old contents leave at the top
  always @(posedge serial_shift_clock)
    if (ser_on) shift_reg <= {shift_reg[6:0], serial_data_in};
  always @(negedge address_enable)
    held_addr <= delay_mode_select ? parallel_program_pins : shift_reg;
  // pin 7 is msb; any of 256 taps, zero the shortest
  assign tap_addr = (delay_mode_select && address_enable) ?
                    parallel_program_pins : held_addr;
  // released line shows the inverse so a stale bit cannot pass
  assign serial_data_out = ser_on ? shift_reg[7] : ~shift_reg[7];
endmodule : dlpi_dev_model

// ==== verification/dlpi_host_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  fail_count++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module dlpi_host_tb;
  import dlpi_pkg::*;
  logic              clock = 0, sys_rst = 1, req_valid = 0, req_restore = 0;
  logic [1:0]        req_op = 2'h0;
  logic [ADDR_W-1:0] req_addr = 8'h00, read_addr, pins, dev_tap;
  logic              req_ready, done, signal_hold, mode, enable;
  logic              sclk, sdi, sdo;
  int                fail_count = 0, total_checks = 0, cycles = 0;
  dlpi_host i_dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_restore(req_restore),
    .req_ready(req_ready), .done(done), .read_addr(read_addr),
    .signal_hold(signal_hold), .delay_mode_select(mode),
    .address_enable(enable), .parallel_program_pins(pins),
    .serial_shift_clock(sclk), .serial_data_in(sdi), .serial_data_out(sdo));
  dlpi_dev_model i_dev (.delay_mode_select(mode), .address_enable(enable),
    .parallel_program_pins(pins), .serial_shift_clock(sclk),
    .serial_data_in(sdi), .serial_data_out(sdo), .tap_addr(dev_tap));
  initial forever #2.5 clock = ~clock;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // seven ops of about 850 cycles; the ceiling allows about three times that
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic run(input logic [1:0] op, input logic [7:0] addr,
                     input logic [7:0] exp_rd, input logic rs);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin @(negedge clock); n++; end
    req_op = op;
    req_addr = addr;
    req_restore = rs;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    req_restore = 1'b0;
    repeat (10) @(negedge clock);
    `CHK("hold", 1'b1, signal_hold)
    `CHK("ready", 1'b0, req_ready)
    n = 0;
    while (done !== 1'b1 && n < 2000) begin @(negedge clock); n++; end
    `CHK("done", 1'b1, done)
    `CHK("hold off", 1'b0, signal_hold)
    `CHK("tap", rs ? exp_rd : addr, dev_tap)
    if (op == OP_SERIAL) `CHK("readback", exp_rd, read_addr)
  endtask : run
  task automatic test_transparent();
    run(OP_TRANSPARENT, 8'h96, 8'h00, 1'b0);
    `CHK("mode", 1'b1, mode)
    `CHK("enable", 1'b1, enable)
    run(OP_TRANSPARENT, 8'h00, 8'h00, 1'b0);
    $display("transparent done");
  endtask : test_transparent
  task automatic test_latched();
    run(OP_LATCHED, 8'h3c, 8'h00, 1'b0);
    `CHK("enable low", 1'b0, enable)
    $display("latched done");
  endtask : test_latched
  // each readback after the first (the model's INIT, 5a) is the value the previous serial op wrote
  task automatic test_serial();
    run(OP_SERIAL, 8'ha5, 8'h5a, 1'b0);
    `CHK("mode", 1'b0, mode)
    run(OP_SERIAL, 8'hff, 8'ha5, 1'b0);
    run(OP_SERIAL, 8'h01, 8'hff, 1'b0);
    // restore: reads 01, shifts 77 in, then writes 01 back before enable falls
    run(OP_SERIAL, 8'h77, 8'h01, 1'b1);
    $display("serial done");
  endtask : test_serial
  initial begin
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    test_transparent();
    test_latched();
    test_serial();
    stop_test();
  end
endmodule : dlpi_host_tb
